//--- hdl/timer_pair.sv
`timescale 1ns/1ps
module timer_pair (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // Register port
  input  wire logic [3:0] address,
  input  wire logic [7:0] write_data,
  input  wire logic       write_strobe,
  input  wire logic       read_strobe,
  output logic      [7:0] read_data,
  // Clock sources and operating state
  input  wire logic       slow_clock_tick,
  input  wire logic       slow_mode,
  // Event inputs, index 0 lower unit, 1 upper unit
  input  wire logic [1:0] event_input_pin,
  // Outputs
  output logic      [1:0] divider_output_pin,
  output logic      [1:0] pulse_width_output_pin,
  output logic            pulse_generator_output_pin,
  output logic      [1:0] timer_match_interrupt,
  output logic            irq
);

  typedef struct packed {
    logic [1:0][7:0]                          ctl;
    logic [1:0][7:0]                          cmp;
    logic [1:0][7:0]                          duty;
    logic [1:0][7:0]                          duty_act;
    logic [1:0][7:0]                          cnt;
    logic [1:0]                               ff;
    logic [1:0]                               match;
    logic [1:0]                               status;
    logic [1:0]                               mask;
    logic                                     dck;
    logic [timer_pair_pkg::DIV_W-1:0]         div;
    logic [timer_pair_pkg::FS_DIV_W-1:0]      fsdiv;
    logic [1:0]                               ev_prev;
    logic [7:0]                               rdata;
  } state_s;

  state_s s;
  state_s next_s;

  // Source tick for one clock select value
  function automatic logic src_tick(
    input logic [2:0]                      sel,
    input logic                            ev_fall,
    input logic [timer_pair_pkg::DIV_W-1:0] div,
    input logic                            fs3,
    input logic                            fs1,
    input logic                            dck,
    input logic                            slow
  );
    logic t;
    t = 1'b0;
    case (sel)
      timer_pair_pkg::CLK_SLOW_OR_FC11: begin
        t = (slow || dck) ? fs3 : &div[timer_pair_pkg::PRE_11-1:0];
      end
      timer_pair_pkg::CLK_FC7: begin
        t = !slow && &div[timer_pair_pkg::PRE_7-1:0];
      end
      timer_pair_pkg::CLK_FC5: begin
        t = !slow && &div[timer_pair_pkg::PRE_5-1:0];
      end
      timer_pair_pkg::CLK_FC3: begin
        t = !slow && &div[timer_pair_pkg::PRE_3-1:0];
      end
      timer_pair_pkg::CLK_FS: begin
        t = fs1;
      end
      timer_pair_pkg::CLK_FC1: begin
        t = !slow && &div[timer_pair_pkg::PRE_1-1:0];
      end
      timer_pair_pkg::CLK_FC: begin
        t = !slow;
      end
      timer_pair_pkg::CLK_EVENT_PIN: begin
        t = ev_fall;
      end
      default: begin
        t = 1'b0;
      end
    endcase
    return t;
  endfunction

  logic        cascade;
  logic [1:0]  tick;
  logic [1:0]  ev_fall;
  logic        fs3;
  logic [15:0] c16;
  logic [15:0] c16_inc;
  logic [15:0] cmp16;
  logic [15:0] duty16;
  logic [7:0]  c8_inc;
  logic [1:0]  clr;
  logic [1:0]  dload;

  always_comb begin
    next_s  = s;
    cascade = s.ctl[1][timer_pair_pkg::CTL_MODE_HI];
    ev_fall = s.ev_prev & ~event_input_pin;
    fs3     = slow_clock_tick && &s.fsdiv;
    clr     = 2'h0;
    c16     = {s.cnt[1], s.cnt[0]};
    c16_inc = c16 + 16'h0001;
    cmp16   = {s.cmp[1], s.cmp[0]};
    duty16  = {s.duty_act[1], s.duty_act[0]};
    c8_inc  = 8'h00;
    dload   = 2'h0;
    for (int i = 0; i < 2; i++) begin
      tick[i] = src_tick(s.ctl[i][timer_pair_pkg::CTL_CLK_HI:timer_pair_pkg::CTL_CLK_LO],
                         ev_fall[i], s.div, fs3, slow_clock_tick, s.dck, slow_mode);
    end

    next_s.match   = 2'h0;
    next_s.div     = s.div + 1'b1;
    next_s.ev_prev = event_input_pin;
    if (slow_clock_tick) begin
      next_s.fsdiv = s.fsdiv + 1'b1;
    end

    // Register writes
    if (write_strobe) begin
      case (address)
        timer_pair_pkg::ADDR_CTL_LOWER, timer_pair_pkg::ADDR_CTL_UPPER: begin
          next_s.ctl[address[0]] = write_data;
          // Initial level loads only while stopped or on the start write
          if (!s.ctl[address[0]][timer_pair_pkg::CTL_START_BIT]) begin
            next_s.ff[address[0]] = write_data[timer_pair_pkg::CTL_TFF_BIT];
          end
        end
        timer_pair_pkg::ADDR_CMP_LOWER, timer_pair_pkg::ADDR_CMP_UPPER: begin
          next_s.cmp[address[0]] = write_data;
        end
        timer_pair_pkg::ADDR_DUTY_LOWER, timer_pair_pkg::ADDR_DUTY_UPPER: begin
          next_s.duty[address[0]] = write_data;
        end
        timer_pair_pkg::ADDR_STATUS: begin
          clr = write_data[1:0];
        end
        timer_pair_pkg::ADDR_MASK: begin
          next_s.mask = write_data[1:0];
        end
        timer_pair_pkg::ADDR_CONFIG: begin
          next_s.dck = write_data[timer_pair_pkg::CFG_DCK_BIT];
        end
        default: begin
          next_s.dck = s.dck;
        end
      endcase
    end

    // Read data stands only in the cycle after the strobe
    next_s.rdata = 8'h00;
    if (read_strobe) begin
      case (address)
        timer_pair_pkg::ADDR_CTL_LOWER:  next_s.rdata = s.ctl[0];
        timer_pair_pkg::ADDR_CTL_UPPER:  next_s.rdata = s.ctl[1];
        timer_pair_pkg::ADDR_CMP_LOWER:  next_s.rdata = s.cmp[0];
        timer_pair_pkg::ADDR_CMP_UPPER:  next_s.rdata = s.cmp[1];
        timer_pair_pkg::ADDR_DUTY_LOWER: next_s.rdata = s.duty_act[0];
        timer_pair_pkg::ADDR_DUTY_UPPER: next_s.rdata = s.duty_act[1];
        timer_pair_pkg::ADDR_CNT_LOWER:  next_s.rdata = s.cnt[0];
        timer_pair_pkg::ADDR_CNT_UPPER:  next_s.rdata = s.cnt[1];
        timer_pair_pkg::ADDR_STATUS:     next_s.rdata = {6'h00, s.status};
        timer_pair_pkg::ADDR_MASK:       next_s.rdata = {6'h00, s.mask};
        timer_pair_pkg::ADDR_CONFIG:     next_s.rdata = {6'h00, slow_mode, s.dck};
        default:                         next_s.rdata = 8'h00;
      endcase
    end

    if (!cascade) begin
      // Two independent 8-bit units
      for (int i = 0; i < 2; i++) begin
        c8_inc = s.cnt[i] + 8'h01;
        if (!s.ctl[i][timer_pair_pkg::CTL_START_BIT]) begin
          next_s.cnt[i] = 8'h00;
        end else if (tick[i]) begin
          case (s.ctl[i][timer_pair_pkg::CTL_MODE_HI:timer_pair_pkg::CTL_MODE_LO])
            timer_pair_pkg::MODE_DIVIDER8: begin
              if (c8_inc == s.cmp[i]) begin
                next_s.cnt[i]   = 8'h00;
                next_s.ff[i]    = ~s.ff[i];
                next_s.match[i] = 1'b1;
              end else begin
                next_s.cnt[i] = c8_inc;
              end
            end
            timer_pair_pkg::MODE_PWM8: begin
              next_s.cnt[i] = c8_inc;
              if (c8_inc == s.duty_act[i]) begin
                next_s.ff[i] = ~s.ff[i];
              end
              if (s.cnt[i] == timer_pair_pkg::CNT8_TOP) begin
                next_s.ff[i]    = ~s.ff[i];
                next_s.match[i] = 1'b1;
              end
            end
            default: begin
              if (c8_inc == s.cmp[i]) begin
                next_s.cnt[i]   = 8'h00;
                next_s.match[i] = 1'b1;
              end else begin
                next_s.cnt[i] = c8_inc;
              end
            end
          endcase
        end
        dload[i] = !s.ctl[i][timer_pair_pkg::CTL_START_BIT] || next_s.match[i];
      end
    end else begin
      // Chained 16-bit counter: upper byte advances on the lower byte carry
      if (!s.ctl[1][timer_pair_pkg::CTL_START_BIT]) begin
        next_s.cnt = 16'h0000;
      end else if (tick[0]) begin
        case (s.ctl[1][timer_pair_pkg::CTL_MODE_HI:timer_pair_pkg::CTL_MODE_LO])
          timer_pair_pkg::MODE_PWM16: begin
            next_s.cnt = c16_inc;
            if (c16_inc == duty16) begin
              next_s.ff[1] = ~s.ff[1];
            end
            if (c16 == timer_pair_pkg::CNT16_TOP) begin
              next_s.ff[1]    = ~s.ff[1];
              next_s.match[1] = 1'b1;
            end
          end
          timer_pair_pkg::MODE_PPG16: begin
            next_s.cnt = c16_inc;
            if (c16_inc == duty16) begin
              next_s.ff[1] = ~s.ff[1];
            end
            if (c16_inc == cmp16) begin
              next_s.cnt      = 16'h0000;
              next_s.ff[1]    = ~s.ff[1];
              next_s.match[1] = 1'b1;
            end
          end
          default: begin
            if (c16_inc == cmp16) begin
              next_s.cnt      = 16'h0000;
              next_s.match[1] = 1'b1;
            end else begin
              next_s.cnt = c16_inc;
            end
          end
        endcase
      end
      dload = {2{!s.ctl[1][timer_pair_pkg::CTL_START_BIT] || next_s.match[1]}};
    end

    // Duty shadow reloads at the period boundary or while stopped
    for (int i = 0; i < 2; i++) begin
      if (dload[i]) begin
        next_s.duty_act[i] = next_s.duty[i];
      end
    end

    // Set wins over a clear in the same cycle
    next_s.status = (s.status & ~clr) | next_s.match;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s          <= '0;
      s.ctl      <= {2{timer_pair_pkg::CTL_RESET}};
      s.cmp      <= {2{timer_pair_pkg::CMP_RESET}};
      s.duty     <= {2{timer_pair_pkg::DUTY_RESET}};
      s.duty_act <= {2{timer_pair_pkg::DUTY_RESET}};
      s.mask     <= timer_pair_pkg::MASK_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign read_data                  = s.rdata;
  assign divider_output_pin         = ~s.ff;
  assign pulse_width_output_pin     = ~s.ff;
  assign pulse_generator_output_pin = ~s.ff[1];
  assign timer_match_interrupt      = s.match;
  assign irq                        = |(s.status & s.mask);

endmodule

//--- hdl/timer_pair_pkg.sv
package timer_pair_pkg;

  // Register indices on the plain port
  localparam logic [3:0] ADDR_CTL_LOWER   = 4'h0;
  localparam logic [3:0] ADDR_CTL_UPPER   = 4'h1;
  localparam logic [3:0] ADDR_CMP_LOWER   = 4'h2;
  localparam logic [3:0] ADDR_CMP_UPPER   = 4'h3;
  localparam logic [3:0] ADDR_DUTY_LOWER  = 4'h4;
  localparam logic [3:0] ADDR_DUTY_UPPER  = 4'h5;
  localparam logic [3:0] ADDR_CNT_LOWER   = 4'h6;
  localparam logic [3:0] ADDR_CNT_UPPER   = 4'h7;
  localparam logic [3:0] ADDR_STATUS      = 4'h8;
  localparam logic [3:0] ADDR_MASK        = 4'h9;
  localparam logic [3:0] ADDR_CONFIG      = 4'ha;

  // Control and config register fields
  localparam int CTL_TFF_BIT    = 7;
  localparam int CTL_CLK_HI     = 6;
  localparam int CTL_CLK_LO     = 4;
  localparam int CTL_START_BIT  = 3;
  localparam int CTL_MODE_HI    = 2;
  localparam int CTL_MODE_LO    = 0;
  localparam int CFG_DCK_BIT    = 0;
  localparam int CFG_SLOW_BIT   = 1;

  // Reset values
  localparam logic [7:0] CTL_RESET  = 8'h00;
  localparam logic [7:0] CMP_RESET  = 8'hff;
  localparam logic [7:0] DUTY_RESET = 8'hff;
  localparam logic [1:0] MASK_RESET = 2'h0;

  // Prescaler widths for fc/2^n and fs/2^3 ticks
  localparam int DIV_W     = 11;
  localparam int FS_DIV_W  = 3;
  localparam int PRE_11    = 11;
  localparam int PRE_7     = 7;
  localparam int PRE_5     = 5;
  localparam int PRE_3     = 3;
  localparam int PRE_1     = 1;

  localparam logic [7:0]  CNT8_TOP  = 8'hff;
  localparam logic [15:0] CNT16_TOP = 16'hffff;

  typedef enum logic [2:0] {
    CLK_SLOW_OR_FC11 = 3'b000,
    CLK_FC7          = 3'b001,
    CLK_FC5          = 3'b010,
    CLK_FC3          = 3'b011,
    CLK_FS           = 3'b100,
    CLK_FC1          = 3'b101,
    CLK_FC           = 3'b110,
    CLK_EVENT_PIN    = 3'b111
  } clk_sel_e;

  typedef enum logic [2:0] {
    MODE_TIMER8   = 3'b000,
    MODE_DIVIDER8 = 3'b001,
    MODE_PWM8     = 3'b010,
    MODE_LOWER16  = 3'b011,
    MODE_TIMER16  = 3'b100,
    MODE_WARMUP   = 3'b101,
    MODE_PWM16    = 3'b110,
    MODE_PPG16    = 3'b111
  } mode_e;

endpackage

//--- verif/timer_pair_assertions.sv
`timescale 1ns/1ps
module timer_pair_assertions (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       reset,
  // Register port
  input wire logic [3:0] address,
  input wire logic [7:0] write_data,
  input wire logic       write_strobe,
  input wire logic       read_strobe,
  input wire logic [7:0] read_data,
  // Outputs
  input wire logic [1:0] divider_output_pin,
  input wire logic [1:0] pulse_width_output_pin,
  input wire logic       pulse_generator_output_pin,
  input wire logic [1:0] timer_match_interrupt,
  input wire logic       irq
);
  logic [2:0] mode0;
  logic [7:0] cmp0;
  logic [1:0] mask_sh;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // Shadows of the lower mode, lower compare and mask registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode0   <= 3'h0;
      cmp0    <= 8'hff;
      mask_sh <= 2'h0;
    end else if (write_strobe && address == 4'h0) begin
      mode0 <= write_data[2:0];
    end else if (write_strobe && address == 4'h2) begin
      cmp0 <= write_data;
    end else if (write_strobe && address == 4'h9) begin
      mask_sh <= write_data[1:0];
    end
  end
  property p_read_idle;
    !$past(read_strobe) |-> read_data == 8'h00;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data outside read slot");
  property p_reset_quiet;
    disable iff (1'b0) reset |=> read_data == 8'h00 && timer_match_interrupt == 2'h0 && !irq;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy in reset");
  property p_reset_pins;
    disable iff (1'b0) reset |=> divider_output_pin == 2'h3 && pulse_generator_output_pin;
  endproperty
  a_reset_pins: assert property (p_reset_pins) else $error("pins low after reset");
  property p_pins_tied;
    divider_output_pin == pulse_width_output_pin
      && pulse_generator_output_pin == divider_output_pin[1];
  endproperty
  a_pins_tied: assert property (p_pins_tied) else $error("output pins disagree");
  property p_div_toggle;
    $changed(divider_output_pin[0]) && mode0 == 3'h1 && !$past(write_strobe)
      |-> timer_match_interrupt[0];
  endproperty
  a_div_toggle: assert property (p_div_toggle) else $error("toggle without match");
  property p_irq_set;
    timer_match_interrupt[0] && mask_sh[0] && !write_strobe |-> ##[0:1] irq;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("unmasked match without irq");
  property p_irq_masked;
    mask_sh == 2'h0 |-> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq while fully masked");
  property p_match_single;
    timer_match_interrupt[0] && cmp0 > 8'h01 && !$past(write_strobe)
      |=> !timer_match_interrupt[0];
  endproperty
  a_match_single: assert property (p_match_single) else $error("match too long");
endmodule

bind timer_pair timer_pair_assertions timer_pair_assertions_i (
  .clk_sys(clk_sys), .reset(reset), .address(address), .write_data(write_data),
  .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
  .divider_output_pin(divider_output_pin), .pulse_width_output_pin(pulse_width_output_pin),
  .pulse_generator_output_pin(pulse_generator_output_pin),
  .timer_match_interrupt(timer_match_interrupt), .irq(irq));

//--- verif/event_source.sv
`timescale 1ns/1ps
module event_source (
  // Clock
  input  wire logic       clk_sys,
  // Event pins, high while idle
  output logic      [1:0] event_input_pin
);
  initial event_input_pin = 2'b11;
  // One low pulse, each level held three machine cycles
  task automatic pulse(input int k);
    @(posedge clk_sys);
    event_input_pin <= (k == 0) ? 2'b10 : 2'b01;
    repeat (3) @(posedge clk_sys);
    event_input_pin <= 2'b11;
    repeat (3) @(posedge clk_sys);
  endtask
endmodule

//--- verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic       clk_sys = 1'b0;
  logic       reset = 1'b1;
  logic [3:0] address = 4'h0;
  logic [7:0] write_data = 8'h00;
  logic       write_strobe = 1'b0;
  logic       read_strobe = 1'b0;
  logic       slow_clock_tick = 1'b0;
  logic [3:0] tick_div = 4'h0;
  logic       slow_mode = 1'b0;
  logic [7:0] read_data;
  logic [1:0] event_input_pin, divider_output_pin, pulse_width_output_pin, timer_match_interrupt;
  logic       pulse_generator_output_pin, irq;
  int         mismatches = 0;
  int         samples_checked = 0;
  int         n;
  logic [7:0] rst_exp [12] = '{8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff,
                               8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  always #20 clk_sys = ~clk_sys;
  // Slow clock tick once every sixteen system cycles
  always @(posedge clk_sys) begin
    tick_div        <= tick_div + 4'h1;
    slow_clock_tick <= (tick_div == 4'hf);
  end

  timer_pair timer_pair_i (
    .clk_sys(clk_sys), .reset(reset), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
    .slow_clock_tick(slow_clock_tick), .slow_mode(slow_mode), .event_input_pin(event_input_pin),
    .divider_output_pin(divider_output_pin), .pulse_width_output_pin(pulse_width_output_pin),
    .pulse_generator_output_pin(pulse_generator_output_pin),
    .timer_match_interrupt(timer_match_interrupt), .irq(irq));
  event_source event_source_i (.clk_sys(clk_sys), .event_input_pin(event_input_pin));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    address      <= a;
    write_data   <= d;
    write_strobe <= 1'b1;
    @(posedge clk_sys);
    write_strobe <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    address     <= a;
    read_strobe <= 1'b1;
    @(posedge clk_sys);
    read_strobe <= 1'b0;
    #1;
    check("read_data", {8'h00, read_data}, {8'h00, exp});
  endtask
  // Cycles from one event to the m-th following: k 0/1 match, 2 lower pin toggle
  task automatic gap(input int k, input int m, output int n);
    logic p;
    int   hits;
    n    = 0;
    hits = -1;
    @(posedge clk_sys);
    #1;
    repeat (3000) begin
      p = divider_output_pin[0];
      @(posedge clk_sys);
      #1;
      if (hits >= 0) n++;
      if (k < 2 ? timer_match_interrupt[k] === 1'b1 : divider_output_pin[0] !== p) hits++;
      if (hits == m) break;
    end
  endtask
  task automatic conclude;
    if (mismatches == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    foreach (rst_exp[i]) rd(4'(i), rst_exp[i]);
    wr(4'h2, 8'h03);
    rd(4'h6, 8'h00);
    wr(4'h9, 8'h01);
    wr(4'h0, 8'h68);
    gap(0, 1, n);
    check("timer_period", 16'(n), 16'h0003);
    @(posedge clk_sys);
    #1;
    check("irq_set", {15'h0, irq}, 16'h0001);
    wr(4'h0, 8'h00);
    wr(4'h8, 8'h03);
    rd(4'h8, 8'h00);
    check("irq_clear", {15'h0, irq}, 16'h0000);
    rd(4'h6, 8'h00);
    wr(4'h0, 8'h80);
    #1;
    check("ff_load", {14'h0, divider_output_pin[0], pulse_width_output_pin[0]}, 16'h0000);
    wr(4'h0, 8'h00);
    #1;
    check("ff_clear", {14'h0, divider_output_pin[0], pulse_width_output_pin[0]}, 16'h0003);
    wr(4'h2, 8'h05);
    wr(4'h0, 8'h69);
    gap(2, 1, n);
    check("half_period", 16'(n), 16'h0005);
    gap(2, 2, n);
    check("full_period", 16'(n), 16'h000a);
    wr(4'h0, 8'h00);
    wr(4'h2, 8'h02);
    wr(4'ha, 8'h01);
    wr(4'h0, 8'h08);
    gap(0, 1, n);
    check("slow_period", 16'(n), 16'h0100);
    // Fast sources stay silent in slow operation
    @(posedge clk_sys);
    slow_mode <= 1'b1;
    wr(4'h0, 8'h00);
    wr(4'h0, 8'h68);
    repeat (8) @(posedge clk_sys);
    rd(4'h6, 8'h00);
    rd(4'ha, 8'h03);
    @(posedge clk_sys);
    slow_mode <= 1'b0;
    wr(4'h0, 8'h00);
    wr(4'h8, 8'h03);
    wr(4'h2, 8'h04);
    wr(4'h0, 8'h78);
    repeat (2) event_source_i.pulse(0);
    rd(4'h6, 8'h02);
    repeat (2) event_source_i.pulse(0);
    rd(4'h8, 8'h01);
    rd(4'h6, 8'h00);
    // 8-bit PWM: toggle at duty and at overflow, period 256 ticks
    wr(4'h0, 8'h00);
    wr(4'h4, 8'h80);
    wr(4'h0, 8'h6a);
    gap(2, 1, n);
    check("pwm_half", 16'(n), 16'h0080);
    gap(2, 2, n);
    check("pwm_period", 16'(n), 16'h0100);
    wr(4'h0, 8'h00);
    wr(4'h2, 8'h02);
    wr(4'h3, 8'h01);
    wr(4'h0, 8'h63);
    wr(4'h1, 8'h0c);
    gap(1, 1, n);
    check("cascade_period", 16'(n), 16'h0102);
    conclude();
  end

  initial begin
    repeat (10000) @(posedge clk_sys);
    mismatches++;
    conclude();
  end
endmodule
